// ==== hw/stcmd_top.sv ====
module stcmd_top #(
  parameter logic [31:0] IDLE_CYCLES = 32'(stcmd_pkg::IDLE_CYC)
) (
  input wire logic clock,
  input wire logic resetn,
  input wire stcmd_pkg::stcmd_cmd_t port0_cmd,
  input wire stcmd_pkg::stcmd_cmd_t port1_cmd,
  output logic port0_ready,
  output logic port1_ready,
  output stcmd_pkg::stcmd_arb_t port_owner,
  output logic resp_valid,
  output logic [7:0] resp_byte,
  output logic resp_last,
  input wire logic resp_ready,
  input wire logic [7:0] event_in,
  output logic srq,
  output stcmd_pkg::stcmd_sp_t setpoints,
  output logic [15:0] volt_trig,
  output logic [15:0] curr_trig,
  output logic output_on,
  output logic init_cont,
  output logic trig_pending,
  output logic abort_pulse
);
  localparam int IDX_W = 5;

  function automatic logic [7:0] idn_byte(input logic [IDX_W-1:0] i);
    idn_byte = stcmd_pkg::IDN_STR[8*(stcmd_pkg::IDN_LEN-1-int'(i)) +: 8];
  endfunction : idn_byte

  function automatic logic is_query(input stcmd_pkg::stcmd_code_t c);
    is_query = c == stcmd_pkg::CMD_EVMASK_RD ||
               c == stcmd_pkg::CMD_EVLATCH_RD ||
               c == stcmd_pkg::CMD_STATUS_RD ||
               c == stcmd_pkg::CMD_SRMASK_RD ||
               c == stcmd_pkg::CMD_IDENT_RD;
  endfunction : is_query

  stcmd_pkg::stcmd_cmd_t cmd;
  stcmd_pkg::stcmd_st_t st_q, st_d;
  stcmd_pkg::stcmd_sp_t sp_q, rdata;
  logic cmd_ready;
  logic [7:0] event_latch_q, event_latch_d;
  logic [7:0] event_mask_q;
  logic [7:0] service_request_mask_q;
  logic [7:0] rsp_q, rsp_d;
  logic rvalid_q, rvalid_d;
  logic rlast_q, rlast_d;
  logic [IDX_W-1:0] idx_q, idx_d;
  logic [15:0] vtrig_q, ctrig_q;
  logic out_on_q, init_cont_q, trig_pend_q, abort_q, srq_q;

  stcmd_arb #(.IDLE_CYCLES(IDLE_CYCLES)) u_arb (
    .clock(clock),
    .resetn(resetn),
    .p0(port0_cmd),
    .p1(port1_cmd),
    .ready(cmd_ready),
    .sel(cmd),
    .p0_ready(port0_ready),
    .p1_ready(port1_ready),
    .owner(port_owner)
  );

  // Queries and recall held off while a response drains; other commands pass
  assign cmd_ready = st_q == stcmd_pkg::ST_IDLE ||
                     (st_q == stcmd_pkg::ST_RSP && !is_query(cmd.code) &&
                      cmd.code != stcmd_pkg::CMD_RECALL);
  wire acc = cmd.valid & cmd_ready;
  wire is_cls = acc & (cmd.code == stcmd_pkg::CMD_CLEAR_STATUS);
  wire is_evl = acc & (cmd.code == stcmd_pkg::CMD_EVLATCH_RD);
  wire is_srw = acc & (cmd.code == stcmd_pkg::CMD_SRMASK_WR);
  wire is_sav = acc & (cmd.code == stcmd_pkg::CMD_SAVE);
  wire is_rcl = acc & (cmd.code == stcmd_pkg::CMD_RECALL);
  wire is_rst = acc & (cmd.code == stcmd_pkg::CMD_RESET);
  wire is_qry = acc & is_query(cmd.code);
  wire loc_ok = cmd.arg < stcmd_pkg::MEM_LOCS;
  wire bad_loc = (is_sav | is_rcl) & !loc_ok;
  wire do_abort = is_rst | (is_rcl & loc_ok);

  wire message_waiting_flag = rvalid_q;
  wire event_summary_flag = |(event_latch_q & event_mask_q);
  wire [7:0] status_base =
    8'(message_waiting_flag) << stcmd_pkg::STAT_MWF |
    8'(event_summary_flag) << stcmd_pkg::STAT_ESF;
  wire master_summary_flag =
    |(status_base & service_request_mask_q & stcmd_pkg::STAT_USED);
  wire [7:0] status_summary_byte =
    status_base | 8'(master_summary_flag) << stcmd_pkg::STAT_MSF;

  wire [7:0] ev_set = (event_in & stcmd_pkg::EVT_USED) |
                      (8'(bad_loc) << stcmd_pkg::EVT_EXE);
  // Clear-status and latch read clear; new events still land
  assign event_latch_d = ((is_cls | is_evl) ? 8'h00 : event_latch_q) | ev_set;

  // Status read leaves every bit alone
  wire [7:0] qval =
    cmd.code == stcmd_pkg::CMD_EVMASK_RD ? event_mask_q :
    cmd.code == stcmd_pkg::CMD_EVLATCH_RD ? event_latch_q :
    cmd.code == stcmd_pkg::CMD_STATUS_RD ? status_summary_byte :
    cmd.code == stcmd_pkg::CMD_SRMASK_RD ? service_request_mask_q :
    idn_byte('0);

  always_comb begin
    st_d = st_q;
    rsp_d = rsp_q;
    rvalid_d = rvalid_q;
    rlast_d = rlast_q;
    idx_d = idx_q;
    case (st_q)
      stcmd_pkg::ST_RCL: st_d = stcmd_pkg::ST_LOAD;
      stcmd_pkg::ST_LOAD: st_d = stcmd_pkg::ST_IDLE;
      stcmd_pkg::ST_RSP: begin
        if (resp_ready) begin
          if (rlast_q) begin
            rvalid_d = 1'b0;
            st_d = stcmd_pkg::ST_IDLE;
          end else begin
            idx_d = idx_q + 5'h01;
            rsp_d = idn_byte(idx_d);
            rlast_d = idx_d == IDX_W'(stcmd_pkg::IDN_LEN - 1);
          end
        end
      end
      default: st_d = st_q;
    endcase
    if (is_qry) begin
      st_d = stcmd_pkg::ST_RSP;
      rvalid_d = 1'b1;
      idx_d = '0;
      rsp_d = qval;
      rlast_d = cmd.code != stcmd_pkg::CMD_IDENT_RD;
    end
    if (is_cls) begin
      rvalid_d = 1'b0;
      st_d = stcmd_pkg::ST_IDLE;
    end
    if (is_rcl & loc_ok) st_d = stcmd_pkg::ST_RCL;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_q <= stcmd_pkg::ST_RCL;
      rsp_q <= 8'h00;
      rvalid_q <= 1'b0;
      rlast_q <= 1'b0;
      idx_q <= '0;
    end else begin
      st_q <= st_d;
      rsp_q <= rsp_d;
      rvalid_q <= rvalid_d;
      rlast_q <= rlast_d;
      idx_q <= idx_d;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      event_latch_q <= stcmd_pkg::EVT_RST;
      event_mask_q <= stcmd_pkg::MASK_RST;
      service_request_mask_q <= stcmd_pkg::MASK_RST;
      srq_q <= 1'b0;
    end else begin
      event_latch_q <= event_latch_d;
      if (acc && cmd.code == stcmd_pkg::CMD_EVMASK_WR) begin
        event_mask_q <= cmd.arg[7:0];
      end
      if (is_srw) service_request_mask_q <= cmd.arg[7:0];
      srq_q <= master_summary_flag;
    end
  end

  stcmd_mem #(
    .W($bits(stcmd_pkg::stcmd_sp_t)),
    .DEPTH(stcmd_pkg::MEM_DEPTH),
    .AW(1)
  ) u_mem (
    .clock(clock),
    .resetn(resetn),
    .wr_en(is_sav & loc_ok),
    .addr(1'b0),
    .wdata(sp_q),
    .rdata(rdata)
  );

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sp_q <= stcmd_pkg::SP_RST;
      vtrig_q <= 16'h0000;
      ctrig_q <= 16'h0000;
      out_on_q <= 1'b0;
      init_cont_q <= 1'b0;
      trig_pend_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      abort_q <= do_abort;
      if (st_q == stcmd_pkg::ST_LOAD) begin
        sp_q <= rdata;
      end else if (is_rst) begin
        sp_q <= stcmd_pkg::SP_RST;
        vtrig_q <= 16'h0000;
        ctrig_q <= 16'h0000;
        out_on_q <= 1'b0;
      end else if (acc) begin
        case (cmd.code)
          stcmd_pkg::CMD_VOLT_WR: sp_q.volt <= cmd.arg;
          stcmd_pkg::CMD_CURR_WR: sp_q.curr <= cmd.arg;
          stcmd_pkg::CMD_VPROT_WR: sp_q.vprot <= cmd.arg;
          stcmd_pkg::CMD_CPROT_WR: sp_q.cprot <= cmd.arg;
          stcmd_pkg::CMD_PERIOD_WR: sp_q.period <= cmd.arg;
          stcmd_pkg::CMD_VTRIG_WR: vtrig_q <= cmd.arg;
          stcmd_pkg::CMD_CTRIG_WR: ctrig_q <= cmd.arg;
          stcmd_pkg::CMD_OUTPUT_WR: out_on_q <= cmd.arg[0];
          default: out_on_q <= out_on_q;
        endcase
      end
      // Abort cancels trigger and continuous mode
      if (do_abort) begin
        init_cont_q <= 1'b0;
        trig_pend_q <= 1'b0;
      end else if (acc && cmd.code == stcmd_pkg::CMD_INIT_WR) begin
        init_cont_q <= cmd.arg[0];
      end else if (acc && cmd.code == stcmd_pkg::CMD_TRIGGER) begin
        trig_pend_q <= 1'b1;
      end
    end
  end

  assign resp_valid = rvalid_q;
  assign resp_byte = rsp_q;
  assign resp_last = rlast_q;
  assign srq = srq_q;
  assign setpoints = sp_q;
  assign volt_trig = vtrig_q;
  assign curr_trig = ctrig_q;
  assign output_on = out_on_q;
  assign init_cont = init_cont_q;
  assign trig_pending = trig_pend_q;
  assign abort_pulse = abort_q;

  property p_status_keep;
    @(posedge clock) disable iff (!resetn)
    acc && cmd.code == stcmd_pkg::CMD_STATUS_RD && ev_set == 8'h00
    |=> rsp_q == $past(status_summary_byte) &&
        event_latch_q == $past(event_latch_q);
  endproperty
  a_status_keep: assert property (p_status_keep)
    else $error("status byte read wrong or cleared state");

  property p_cls_mwf;
    @(posedge clock) disable iff (!resetn)
    is_cls |=> !resp_valid && event_latch_q == $past(ev_set);
  endproperty
  a_cls_mwf: assert property (p_cls_mwf)
    else $error("clear-status left flags set");

  property p_status_layout;
    @(posedge clock) disable iff (!resetn)
    (status_summary_byte & 8'h8F) == 8'h00 &&
    status_summary_byte[stcmd_pkg::STAT_MWF] == resp_valid;
  endproperty
  a_status_layout: assert property (p_status_layout)
    else $error("status byte layout wrong");

  property p_master_sum;
    @(posedge clock) disable iff (!resetn)
    service_request_mask_q[stcmd_pkg::STAT_ESF] && event_summary_flag
    |=> srq;
  endproperty
  a_master_sum: assert property (p_master_sum)
    else $error("enabled event summary did not raise request");

  property p_srmask_zero;
    @(posedge clock) disable iff (!resetn)
    service_request_mask_q == 8'h00 |=> !srq;
  endproperty
  a_srmask_zero: assert property (p_srmask_zero)
    else $error("request raised with zero mask");

  property p_srmask_wr;
    @(posedge clock) disable iff (!resetn)
    is_srw |=> service_request_mask_q == $past(cmd.arg[7:0]);
  endproperty
  a_srmask_wr: assert property (p_srmask_wr)
    else $error("service request mask not written");

  property p_rcl_abort;
    @(posedge clock) disable iff (!resetn)
    is_rcl && loc_ok |=> abort_pulse && !init_cont && !trig_pending
    ##2 setpoints == $past(rdata);
  endproperty
  a_rcl_abort: assert property (p_rcl_abort)
    else $error("recall did not abort then restore");

  property p_rst;
    @(posedge clock) disable iff (!resetn)
    is_rst |=> !output_on && setpoints == stcmd_pkg::SP_RST &&
               abort_pulse && volt_trig == 16'h0000;
  endproperty
  a_rst: assert property (p_rst)
    else $error("reset defaults not applied");

  property p_bad_loc;
    @(posedge clock) disable iff (!resetn)
    bad_loc |=> event_latch_q[stcmd_pkg::EVT_EXE] &&
                setpoints == $past(setpoints) && !abort_pulse;
  endproperty
  a_bad_loc: assert property (p_bad_loc)
    else $error("bad location not rejected");

  property p_open_claim1;
    @(posedge clock) disable iff (!resetn)
    port_owner == stcmd_pkg::ARB_OPEN && !port0_cmd.valid &&
    port1_cmd.valid |=> port_owner == stcmd_pkg::ARB_P1;
  endproperty
  a_open_claim1: assert property (p_open_claim1)
    else $error("second port traffic did not claim open arbiter");

  property p_owner1_holds;
    @(posedge clock) disable iff (!resetn)
    port_owner == stcmd_pkg::ARB_P1 && !port1_cmd.valid
    |-> !acc && port0_ready;
  endproperty
  a_owner1_holds: assert property (p_owner1_holds)
    else $error("inactive first port command was executed");
endmodule : stcmd_top

// ==== hw/stcmd_pkg.sv ====
package stcmd_pkg;
  localparam longint unsigned CLK_HZ = 10_000_000;
  localparam longint unsigned IDLE_TIME_S = 300;
  localparam longint unsigned IDLE_CYC = IDLE_TIME_S * CLK_HZ;
  localparam int SP_W = 16;
  localparam logic [15:0] SP_FULL = 16'h0FFF;
  localparam int PROT_PCT = 110;
  localparam logic [15:0] PROT_DEF = 16'((32'(SP_FULL) * PROT_PCT) / 100);
  localparam int STAT_MWF = 4;
  localparam int STAT_ESF = 5;
  localparam int STAT_MSF = 6;
  localparam logic [7:0] STAT_USED = 8'h30;
  localparam int EVT_EXE = 4;
  localparam logic [7:0] EVT_USED = 8'hBD;
  localparam logic [7:0] EVT_RST = 8'h80;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [15:0] MEM_LOCS = 16'h0001;
  localparam int MEM_DEPTH = 1;
  localparam int IDN_LEN = 18;
  // Identification text, arbitrary
  localparam logic [8*IDN_LEN-1:0] IDN_STR = "MAKER,MODEL,SN0000";

  typedef enum logic [4:0] {
    CMD_CLEAR_STATUS = 5'h00, CMD_EVMASK_WR = 5'h01, CMD_EVMASK_RD = 5'h02,
    CMD_EVLATCH_RD = 5'h03, CMD_STATUS_RD = 5'h04, CMD_SRMASK_WR = 5'h05,
    CMD_SRMASK_RD = 5'h06, CMD_IDENT_RD = 5'h07, CMD_SAVE = 5'h08,
    CMD_RECALL = 5'h09, CMD_RESET = 5'h0A, CMD_VOLT_WR = 5'h0B,
    CMD_CURR_WR = 5'h0C, CMD_VPROT_WR = 5'h0D, CMD_CPROT_WR = 5'h0E,
    CMD_PERIOD_WR = 5'h0F, CMD_VTRIG_WR = 5'h10, CMD_CTRIG_WR = 5'h11,
    CMD_OUTPUT_WR = 5'h12, CMD_INIT_WR = 5'h13, CMD_TRIGGER = 5'h14
  } stcmd_code_t;

  typedef enum logic [1:0] {
    ARB_OPEN = 2'h0, ARB_P0 = 2'h1, ARB_P1 = 2'h3
  } stcmd_arb_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0, ST_RCL = 2'h1, ST_LOAD = 2'h3, ST_RSP = 2'h2
  } stcmd_st_t;

  typedef struct packed {
    logic valid;
    stcmd_code_t code;
    logic [15:0] arg;
  } stcmd_cmd_t;

  typedef struct packed {
    logic [15:0] volt;
    logic [15:0] curr;
    logic [15:0] vprot;
    logic [15:0] cprot;
    logic [15:0] period;
  } stcmd_sp_t;

  localparam stcmd_sp_t SP_RST = '{16'h0000, 16'h0000, PROT_DEF, PROT_DEF,
                                   16'h0000};
endpackage : stcmd_pkg

// ==== hw/stcmd_mem.sv ====
module stcmd_mem #(
  parameter int W = 80,
  parameter int DEPTH = 1,
  parameter int AW = 1
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic wr_en,
  input wire logic [AW-1:0] addr,
  input wire logic [W-1:0] wdata,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem [DEPTH];

  // Contents survive the block reset
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata <= '0;
    end else begin
      rdata <= mem[addr];
    end
  end
endmodule : stcmd_mem

// ==== hw/stcmd_arb.sv ====
module stcmd_arb #(
  parameter logic [31:0] IDLE_CYCLES = 32'(stcmd_pkg::IDLE_CYC)
) (
  input wire logic clock,
  input wire logic resetn,
  input wire stcmd_pkg::stcmd_cmd_t p0,
  input wire stcmd_pkg::stcmd_cmd_t p1,
  input wire logic ready,
  output stcmd_pkg::stcmd_cmd_t sel,
  output logic p0_ready,
  output logic p1_ready,
  output stcmd_pkg::stcmd_arb_t owner
);
  stcmd_pkg::stcmd_arb_t st_q, st_d;
  logic [31:0] idle_q, idle_d;

  wire open = st_q == stcmd_pkg::ARB_OPEN;
  wire take0 = open | (st_q == stcmd_pkg::ARB_P0);
  wire take1 = (open & !p0.valid) | (st_q == stcmd_pkg::ARB_P1);
  wire act = (take0 & p0.valid) | (take1 & p1.valid);
  assign p0_ready = take0 ? ready : 1'b1;
  assign p1_ready = take1 ? ready : 1'b1;
  assign sel = (take0 & p0.valid) ? p0 : (take1 & p1.valid) ? p1 : '0;
  assign owner = st_q;

  always_comb begin
    st_d = st_q;
    idle_d = 32'h0000_0000;
    if (open) begin
      if (p0.valid) st_d = stcmd_pkg::ARB_P0;
      else if (p1.valid) st_d = stcmd_pkg::ARB_P1;
    end else if (!act) begin
      idle_d = idle_q + 32'h0000_0001;
      if (idle_d >= IDLE_CYCLES) begin
        st_d = stcmd_pkg::ARB_OPEN;
        idle_d = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_q <= stcmd_pkg::ARB_OPEN;
      idle_q <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
      idle_q <= idle_d;
    end
  end

  property p_first_claims;
    @(posedge clock) disable iff (!resetn)
    open && p0.valid |=> st_q == stcmd_pkg::ARB_P0;
  endproperty
  a_first_claims: assert property (p_first_claims)
    else $error("first port with traffic not made active");

  property p_other_ignored;
    @(posedge clock) disable iff (!resetn)
    st_q == stcmd_pkg::ARB_P0 && !p0.valid |-> !sel.valid && p1_ready;
  endproperty
  a_other_ignored: assert property (p_other_ignored)
    else $error("inactive port traffic passed through");
endmodule : stcmd_arb

// ==== verification/stcmd_ctl.sv ====
module stcmd_ctl (
  input wire logic clock,
  output stcmd_pkg::stcmd_cmd_t port0_cmd,
  output stcmd_pkg::stcmd_cmd_t port1_cmd,
  input wire logic port0_ready,
  input wire logic port1_ready,
  input wire logic resp_valid,
  input wire logic [7:0] resp_byte,
  input wire logic resp_last,
  output logic resp_ready,
  output logic hung
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    port0_cmd = '0;
    port1_cmd = '0;
    resp_ready = 1'b0;
    hung = 1'b0;
  end

  // Hold command until taken, then scramble the released fields
  task automatic send(input logic p, input stcmd_pkg::stcmd_code_t c,
                      input logic [15:0] a);
    stcmd_pkg::stcmd_cmd_t m;
    int n;
    m = '{1'b1, c, a};
    n = 0;
    @(negedge clock);
    if (p) port1_cmd = m;
    else port0_cmd = m;
    #1;
    while ((p ? port1_ready : port0_ready) !== 1'b1 && n < 200) begin
      @(negedge clock);
      #1;
      n++;
    end
    if (n >= 200) hung = 1'b1;
    @(negedge clock);
    m = '{1'b0, stcmd_pkg::stcmd_code_t'(~c), ~a};
    if (p) port1_cmd = m;
    else port0_cmd = m;
  endtask : send

  // Take one response byte, optionally stalling first
  task automatic get(input int stall, output logic [7:0] b,
                     output logic l);
    int n;
    n = 0;
    @(negedge clock);
    while (resp_valid !== 1'b1 && n < 200) begin
      @(negedge clock);
      n++;
    end
    if (n >= 200) hung = 1'b1;
    repeat (stall) @(negedge clock);
    b = resp_byte;
    l = resp_last;
    resp_ready = 1'b1;
    @(negedge clock);
    resp_ready = 1'b0;
  endtask : get
endmodule : stcmd_ctl

// ==== verification/tb.sv ====
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] IDLE = 32'h14;
  localparam logic [15:0] PROT =
    16'((32'(stcmd_pkg::SP_FULL) * 110) / 100);
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] event_in = 8'h00;
  logic resp_ready, srq, p0r, p1r, rv, rl, out_on, icont, tpend, abp;
  logic hung, l;
  logic [7:0] rb, b;
  logic [15:0] vt, ct;
  logic [15:0] vals [5] = '{16'h0123, 16'h0045, 16'h0800, 16'h0900,
                            16'h0007};
  stcmd_pkg::stcmd_cmd_t c0, c1;
  stcmd_pkg::stcmd_arb_t owner;
  stcmd_pkg::stcmd_sp_t sp, saved;
  int errors = 0;
  int n_checks = 0;
  int n_abort = 0;
  int a0, nc;

  always #50 clock = ~clock;
  always @(posedge clock) if (abp === 1'b1) n_abort++;

  stcmd_top #(.IDLE_CYCLES(IDLE)) dut (.clock(clock), .resetn(resetn),
    .port0_cmd(c0), .port1_cmd(c1), .port0_ready(p0r),
    .port1_ready(p1r), .port_owner(owner), .resp_valid(rv),
    .resp_byte(rb), .resp_last(rl), .resp_ready(resp_ready),
    .event_in(event_in), .srq(srq), .setpoints(sp), .volt_trig(vt),
    .curr_trig(ct), .output_on(out_on), .init_cont(icont),
    .trig_pending(tpend), .abort_pulse(abp));

  stcmd_ctl ctl (.clock(clock), .port0_cmd(c0), .port1_cmd(c1),
    .port0_ready(p0r), .port1_ready(p1r), .resp_valid(rv),
    .resp_byte(rb), .resp_last(rl), .resp_ready(resp_ready),
    .hung(hung));

  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk8

  task automatic chk_sp(input stcmd_pkg::stcmd_sp_t g,
                        input stcmd_pkg::stcmd_sp_t e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk_sp

  task automatic w(input logic p, input stcmd_pkg::stcmd_code_t c,
                   input logic [15:0] a);
    ctl.send(p, c, a);
    @(negedge clock);
  endtask : w

  task automatic q(input logic p, input stcmd_pkg::stcmd_code_t c,
                   output logic [7:0] r);
    ctl.send(p, c, 16'h0000);
    ctl.get(0, r, l);
  endtask : q

  always @(posedge hung) begin
    errors++;
    conclude();
  end

  initial begin
    repeat (8) @(negedge clock);
    resetn = 1'b1;
    repeat (3) @(negedge clock);
    chk8(8'(owner), 8'(stcmd_pkg::ARB_OPEN));
    q(0, stcmd_pkg::CMD_STATUS_RD, b);
    chk8(b, 8'h00);
    chk8(8'(owner), 8'(stcmd_pkg::ARB_P0));
    w(0, stcmd_pkg::CMD_EVMASK_WR, 16'h0080);
    q(0, stcmd_pkg::CMD_STATUS_RD, b);
    chk8(b, 8'h20);
    q(0, stcmd_pkg::CMD_STATUS_RD, b);
    chk8(b, 8'h20);
    w(0, stcmd_pkg::CMD_SRMASK_WR, 16'h0020);
    q(0, stcmd_pkg::CMD_SRMASK_RD, b);
    chk8(b, 8'h20);
    q(0, stcmd_pkg::CMD_STATUS_RD, b);
    chk8(b, 8'h60);
    chk8({7'h00, srq}, 8'h01);
    w(0, stcmd_pkg::CMD_SRMASK_WR, 16'h0000);
    repeat (2) @(negedge clock);
    chk8({7'h00, srq}, 8'h00);
    q(0, stcmd_pkg::CMD_EVLATCH_RD, b);
    chk8(b, 8'h80);
    q(0, stcmd_pkg::CMD_EVLATCH_RD, b);
    chk8(b, 8'h00);
    event_in = 8'h01;
    @(negedge clock);
    event_in = 8'h00;
    q(0, stcmd_pkg::CMD_STATUS_RD, b);
    chk8(b, 8'h00);
    w(0, stcmd_pkg::CMD_EVMASK_WR, 16'h0001);
    q(0, stcmd_pkg::CMD_EVMASK_RD, b);
    chk8(b, 8'h01);
    q(0, stcmd_pkg::CMD_STATUS_RD, b);
    chk8(b, 8'h20);
    ctl.send(0, stcmd_pkg::CMD_IDENT_RD, 16'h0000);
    repeat (2) @(negedge clock);
    chk8({7'h00, rv}, 8'h01);
    w(0, stcmd_pkg::CMD_CLEAR_STATUS, 16'h0000);
    chk8({7'h00, rv}, 8'h00);
    q(0, stcmd_pkg::CMD_EVLATCH_RD, b);
    chk8(b, 8'h00);
    q(0, stcmd_pkg::CMD_STATUS_RD, b);
    chk8(b, 8'h00);
    // Identity text with a slow reader
    ctl.send(0, stcmd_pkg::CMD_IDENT_RD, 16'h0000);
    nc = 0;
    for (int i = 0; i < stcmd_pkg::IDN_LEN; i++) begin
      ctl.get(i % 3, b, l);
      chk8(b, stcmd_pkg::IDN_STR[8*(stcmd_pkg::IDN_LEN-1-i) +: 8]);
      chk8({7'h00, l}, {7'h00, i == stcmd_pkg::IDN_LEN - 1});
      if (b == 8'h2C) nc++;
    end
    chk8(8'(nc), 8'h02);
    for (int i = 0; i < 5; i++) begin
      w(0, stcmd_pkg::stcmd_code_t'(stcmd_pkg::CMD_VOLT_WR + i), vals[i]);
    end
    saved = '{vals[0], vals[1], vals[2], vals[3], vals[4]};
    chk_sp(sp, saved);
    w(0, stcmd_pkg::CMD_VTRIG_WR, 16'h0111);
    w(0, stcmd_pkg::CMD_CTRIG_WR, 16'h0022);
    w(0, stcmd_pkg::CMD_OUTPUT_WR, 16'h0001);
    w(0, stcmd_pkg::CMD_INIT_WR, 16'h0001);
    w(0, stcmd_pkg::CMD_TRIGGER, 16'h0000);
    chk_sp({vt, ct, 13'h0000, out_on, icont, tpend, 32'h0},
           {16'h0111, 16'h0022, 13'h0000, 3'h7, 32'h0});
    w(0, stcmd_pkg::CMD_SAVE, 16'h0000);
    a0 = n_abort;
    w(0, stcmd_pkg::CMD_RESET, 16'h0000);
    @(negedge clock);
    chk_sp(sp, '{16'h0000, 16'h0000, PROT, PROT, 16'h0000});
    chk_sp({vt, ct, 13'h0000, out_on, icont, tpend, 32'h0}, '0);
    chk8(8'(n_abort - a0), 8'h01);
    w(0, stcmd_pkg::CMD_INIT_WR, 16'h0001);
    w(0, stcmd_pkg::CMD_TRIGGER, 16'h0000);
    chk8({7'h00, icont}, 8'h01);
    a0 = n_abort;
    w(0, stcmd_pkg::CMD_RECALL, 16'h0000);
    repeat (4) @(negedge clock);
    chk_sp(sp, saved);
    chk8({6'h00, icont, tpend}, 8'h00);
    chk8(8'(n_abort - a0), 8'h01);
    w(0, stcmd_pkg::CMD_CLEAR_STATUS, 16'h0000);
    w(0, stcmd_pkg::CMD_VOLT_WR, 16'h0AAA);
    w(0, stcmd_pkg::CMD_SAVE, 16'h0001);
    w(0, stcmd_pkg::CMD_RECALL, 16'h0001);
    repeat (4) @(negedge clock);
    chk_sp(sp, {16'h0AAA, saved[63:0]});
    q(0, stcmd_pkg::CMD_EVLATCH_RD, b);
    chk8(b, 8'h10);
    w(0, stcmd_pkg::CMD_RECALL, 16'h0000);
    repeat (4) @(negedge clock);
    chk_sp(sp, saved);
    // Power cycle reloads the stored state
    resetn = 1'b0;
    repeat (2) @(negedge clock);
    resetn = 1'b1;
    repeat (4) @(negedge clock);
    chk_sp(sp, saved);
    chk8(8'(owner), 8'(stcmd_pkg::ARB_OPEN));
    w(1, stcmd_pkg::CMD_SRMASK_WR, 16'h0030);
    chk8(8'(owner), 8'(stcmd_pkg::ARB_P1));
    w(0, stcmd_pkg::CMD_SRMASK_WR, 16'h0010);
    q(1, stcmd_pkg::CMD_SRMASK_RD, b);
    chk8(b, 8'h30);
    repeat (IDLE + 4) @(negedge clock);
    chk8(8'(owner), 8'(stcmd_pkg::ARB_OPEN));
    w(0, stcmd_pkg::CMD_SRMASK_WR, 16'h0010);
    chk8(8'(owner), 8'(stcmd_pkg::ARB_P0));
    q(0, stcmd_pkg::CMD_SRMASK_RD, b);
    chk8(b, 8'h10);
    conclude();
  end
endmodule : tb
